// *** verilog/sbt_defines.vh ***
/*
 * Register map, field positions, reset values and timing counts for the
 * serial-link bit error tester control block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SBT_DEFINES_VH
`define SBT_DEFINES_VH

// Register offsets (byte addresses, one aligned word each)
`define SBT_OFF_CTRL      8'h00
`define SBT_OFF_PATTERN   8'h04
`define SBT_OFF_CMD       8'h08
`define SBT_OFF_STATUS    8'h0C
`define SBT_OFF_BITCNT    8'h10
`define SBT_OFF_ERRCNT    8'h14
`define SBT_OFF_RATIO     8'h18
`define SBT_OFF_LINERATE  8'h1C
`define SBT_OFF_FREQ01    8'h20
`define SBT_OFF_FREQ23    8'h24
`define SBT_OFF_DCP_ADDR  8'h28
`define SBT_OFF_DCP_DATA  8'h2C
`define SBT_OFF_PORT_WR   8'h30
`define SBT_OFF_PORT_RD   8'h34

// CTRL fields
`define SBT_CTRL_LB_LSB   0
`define SBT_CTRL_LB_MSB   2
`define SBT_CTRL_TXINV    3
`define SBT_CTRL_RXINV    4
`define SBT_CTRL_RESET    32'h0000_0000

// Loopback codes
`define SBT_LB_NONE       3'h0
`define SBT_LB_NE_PCS     3'h1
`define SBT_LB_NE_PMA     3'h2
`define SBT_LB_FE_PMA     3'h3
`define SBT_LB_FE_PCS     3'h4

// Pattern codes and fields
`define SBT_PAT_PRBS7     3'h0
`define SBT_PAT_PRBS15    3'h1
`define SBT_PAT_PRBS23    3'h2
`define SBT_PAT_PRBS31    3'h3
`define SBT_PAT_CLK2X     3'h4
`define SBT_PAT_CLK10X    3'h5
`define SBT_PAT_TX_LSB    0
`define SBT_PAT_RX_LSB    4

// Command bits (write one to fire, self clearing)
`define SBT_CMD_PAIR_RST  0
`define SBT_CMD_CHAN_RST  1
`define SBT_CMD_ERR_INJ   2
`define SBT_CMD_TEST_RST  3
`define SBT_CMD_TXCM_RST  4
`define SBT_CMD_RXCM_RST  5

// Reset pulse length and frequency gate
`define SBT_RST_CYCLES    8'h10
`define SBT_CLK_MHZ       10
`define SBT_GATE_US       100
`define SBT_GATE_CYCLES   (`SBT_GATE_US * `SBT_CLK_MHZ)
`define SBT_FREQ_SHIFT    7

`endif

// *** verilog/sbt_control.v ***
/*
 * Control and status block of one serial transceiver channel bit error
 * tester: loopback, resets, polarity, error inject, pattern select,
 * counters with ratio, lock status, user clock meters and dynamic
 * configuration port access, all over an Avalon-MM slave.
 * Assumes i_clk at 10 MHz, synchronous active-low reset, and that the
 * transceiver reports checker results as one-cycle pulses on i_clk.
 * Reads wait one cycle; config port
 * accesses wait for the port's answer.
 */
// How it works
// R1 - Loopback register picks one of five modes
// R2 - Near PCS mode drives PCS-only return path
// R3 - Near PMA mode drives PCS-PMA-PCS return path
// R4 - Far PMA mode returns RX pins via PMA
// R5 - Far PCS mode returns via PMA and PCS
// R6 - Pair reset pulses both channels' resets
// R7 - Channel reset pulses this channel only
// R8 - TX invert flips transmitted serial polarity
// R9 - RX invert flips received serial polarity
// R10 - Inject command flips one bit once
// R11 - Independent TX and RX pattern select
// R12 - Count received bits, cleared by test reset
// R13 - Count bit errors, cleared by test reset
// R14 - Test reset clears both counters together
// R15 - Ratio equals errors over received bits
// R16 - Report link state and line rate
// R17 - Report transceiver PLL lock per channel
// R18 - Separate TX and RX clock manager resets
// R19 - Measure four user clocks in MHz
// R20 - Config port writes apply now, read back
// R21 - Writable ports driven at once, others read
// R22 - Counters saturate rather than wrap
// R23 - Host polls registers over a debug bus
`timescale 1ns/1ps
`include "sbt_defines.vh"

module sbt_control (
    input  wire        i_clk,
    input  wire        i_rst_b,
    // Avalon-MM slave
    input  wire [7:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    // Transceiver controls
    output reg  [2:0]  o_loopback,
    output wire        o_lb_ne_pcs,
    output wire        o_lb_ne_pma,
    output wire        o_lb_fe_pma,
    output wire        o_lb_fe_pcs,
    output wire        o_pair_rst,
    output wire        o_chan_rst,
    output wire        o_tx_invert,
    output wire        o_rx_invert,
    output reg         o_err_inject,
    output reg  [2:0]  o_tx_pattern,
    output reg  [2:0]  o_rx_pattern,
    output wire        o_tx_cm_rst,
    output wire        o_rx_cm_rst,
    // Checker results, same clock domain
    input  wire        i_rx_word_valid,
    input  wire [5:0]  i_rx_word_bits,
    input  wire [5:0]  i_rx_word_errs,
    // Status pins from other domains
    input  wire        i_link_up,
    input  wire        i_pll_lock,
    input  wire        i_tx_user_clock,
    input  wire        i_tx_user_clock_fabric,
    input  wire        i_rx_user_clock,
    input  wire        i_rx_user_clock_fabric,
    // Dynamic configuration port
    output reg  [7:0]  o_dcp_addr,
    output reg  [15:0] o_dcp_wdata,
    output reg         o_dcp_we,
    output reg         o_dcp_en,
    input  wire [15:0] i_dcp_rdata,
    input  wire        i_dcp_ready,
    // General transceiver ports
    output reg  [15:0] o_port_ctrl,
    input  wire [15:0] i_port_status
);

    reg  [31:0] ctrl;
    reg  [7:0]  pair_cnt;
    reg  [7:0]  chan_cnt;
    reg  [7:0]  txcm_cnt;
    reg  [7:0]  rxcm_cnt;
    reg  [47:0] bit_cnt;
    reg  [31:0] err_cnt;
    reg  [31:0] ratio;
    reg  [47:0] div_rem;
    reg  [5:0]  div_step;
    reg         div_busy;
    reg  [31:0] ratio_q;
    reg  [15:0] dcp_data;
    reg         dcp_busy;
    reg         dcp_rd_pend;
    reg         rd_ack;
    reg  [2:0]  link_s;
    reg  [2:0]  pll_s;
    reg         link_st;
    reg         pll_st;
    reg  [11:0] gate_cnt;
    reg  [7:0]  clk_mhz [0:3];
    reg  [15:0] edge_cnt [0:3];
    reg  [2:0]  clk_s [0:3];
    reg  [31:0] next_rdata;
    integer     k;

    // Gate reload value; only the low
    // 12 bits reach the counter
    localparam [31:0] GATE_LAST = `SBT_GATE_CYCLES - 1;

    wire [3:0]  clk_in = {i_rx_user_clock_fabric, i_rx_user_clock,
                          i_tx_user_clock_fabric, i_tx_user_clock};
    wire        wr = i_avs_write;
    wire        rd = i_avs_read;
    wire        dcp_acc = (i_avs_address == `SBT_OFF_DCP_DATA) && (wr || rd);
    wire        gate_end = (gate_cnt == 12'd0);

    // Config port accesses stall until the
    // port has answered; every read stalls
    // one cycle so registered data stands
    // at the accepting edge
    assign o_avs_waitrequest = (rd && !rd_ack) // R23
                               || (dcp_acc && !dcp_busy); // R20

    // Loopback decode: at most one path active, none when code is NONE
    assign o_lb_ne_pcs = (o_loopback == `SBT_LB_NE_PCS); // R2
    assign o_lb_ne_pma = (o_loopback == `SBT_LB_NE_PMA); // R3
    assign o_lb_fe_pma = (o_loopback == `SBT_LB_FE_PMA); // R4
    assign o_lb_fe_pcs = (o_loopback == `SBT_LB_FE_PCS); // R5

    assign o_tx_invert = ctrl[`SBT_CTRL_TXINV]; // R8
    assign o_rx_invert = ctrl[`SBT_CTRL_RXINV]; // R9

    // Resets held for a fixed pulse so the transceiver sees a clean reset
    assign o_pair_rst  = (pair_cnt != 8'h00); // R6
    assign o_chan_rst  = (chan_cnt != 8'h00) || o_pair_rst; // R7
    assign o_tx_cm_rst = (txcm_cnt != 8'h00); // R18
    assign o_rx_cm_rst = (rxcm_cnt != 8'h00); // R18

    // Control register and pattern select
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctrl         <= `SBT_CTRL_RESET;
            o_loopback   <= `SBT_LB_NONE;
            o_tx_pattern <= `SBT_PAT_PRBS7;
            o_rx_pattern <= `SBT_PAT_PRBS7;
            o_port_ctrl  <= 16'h0000;
        end else if (wr) begin
            if (i_avs_address == `SBT_OFF_CTRL) begin
                ctrl <= i_avs_writedata;
                // Illegal codes fall back to no loopback
                if (i_avs_writedata[`SBT_CTRL_LB_MSB:`SBT_CTRL_LB_LSB] <= `SBT_LB_FE_PCS) begin
                    o_loopback <= i_avs_writedata[`SBT_CTRL_LB_MSB:`SBT_CTRL_LB_LSB]; // R1
                end else begin
                    o_loopback <= `SBT_LB_NONE; // R1
                end
            end
            if (i_avs_address == `SBT_OFF_PATTERN) begin
                if (i_avs_writedata[`SBT_PAT_TX_LSB+2:`SBT_PAT_TX_LSB] <= `SBT_PAT_CLK10X)
                    o_tx_pattern <= i_avs_writedata[`SBT_PAT_TX_LSB+2:`SBT_PAT_TX_LSB]; // R11
                if (i_avs_writedata[`SBT_PAT_RX_LSB+2:`SBT_PAT_RX_LSB] <= `SBT_PAT_CLK10X)
                    o_rx_pattern <= i_avs_writedata[`SBT_PAT_RX_LSB+2:`SBT_PAT_RX_LSB]; // R11
            end
            if (i_avs_address == `SBT_OFF_PORT_WR)
                o_port_ctrl <= i_avs_writedata[15:0]; // R21
        end
    end

    // Command pulses and reset stretchers
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            pair_cnt     <= 8'h00;
            chan_cnt     <= 8'h00;
            txcm_cnt     <= 8'h00;
            rxcm_cnt     <= 8'h00;
            o_err_inject <= 1'b0;
        end else begin
            o_err_inject <= wr && (i_avs_address == `SBT_OFF_CMD)
                            && i_avs_writedata[`SBT_CMD_ERR_INJ]; // R10
            if (wr && (i_avs_address == `SBT_OFF_CMD) && i_avs_writedata[`SBT_CMD_PAIR_RST])
                pair_cnt <= `SBT_RST_CYCLES; // R6
            else if (pair_cnt != 8'h00)
                pair_cnt <= pair_cnt - 8'h01;
            if (wr && (i_avs_address == `SBT_OFF_CMD) && i_avs_writedata[`SBT_CMD_CHAN_RST])
                chan_cnt <= `SBT_RST_CYCLES; // R7
            else if (chan_cnt != 8'h00)
                chan_cnt <= chan_cnt - 8'h01;
            if (wr && (i_avs_address == `SBT_OFF_CMD) && i_avs_writedata[`SBT_CMD_TXCM_RST])
                txcm_cnt <= `SBT_RST_CYCLES; // R18
            else if (txcm_cnt != 8'h00)
                txcm_cnt <= txcm_cnt - 8'h01;
            if (wr && (i_avs_address == `SBT_OFF_CMD) && i_avs_writedata[`SBT_CMD_RXCM_RST])
                rxcm_cnt <= `SBT_RST_CYCLES; // R18
            else if (rxcm_cnt != 8'h00)
                rxcm_cnt <= rxcm_cnt - 8'h01;
        end
    end

    // Bit and error counters; test reset wins, otherwise saturating add
    // A word arriving with a clear is dropped
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            bit_cnt <= 48'h0000_0000_0000;
            err_cnt <= 32'h0000_0000;
        end else if ((wr && (i_avs_address == `SBT_OFF_CMD)
                      && i_avs_writedata[`SBT_CMD_TEST_RST]) || o_chan_rst) begin
            bit_cnt <= 48'h0000_0000_0000; // R14
            err_cnt <= 32'h0000_0000; // R14
        end else if (i_rx_word_valid) begin
            if (bit_cnt > 48'hFFFF_FFFF_FFFF - {42'h0, i_rx_word_bits})
                bit_cnt <= 48'hFFFF_FFFF_FFFF; // R22
            else
                bit_cnt <= bit_cnt + {42'h0, i_rx_word_bits}; // R12
            if (err_cnt > 32'hFFFF_FFFF - {26'h0, i_rx_word_errs})
                err_cnt <= 32'hFFFF_FFFF; // R22
            else
                err_cnt <= err_cnt + {26'h0, i_rx_word_errs}; // R13
        end
    end

    // Serial divider: ratio = err/bits as a 32-bit binary fraction.
    // Restarts when idle, so the value lags the counters by 33 cycles.
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            div_rem  <= 48'h0000_0000_0000;
            div_step <= 6'h00;
            div_busy <= 1'b0;
            ratio_q  <= 32'h0000_0000;
            ratio    <= 32'h0000_0000;
        end else if (!div_busy) begin
            div_rem  <= {16'h0000, err_cnt};
            div_step <= 6'h00;
            div_busy <= 1'b1;
            ratio_q  <= 32'h0000_0000;
        end else if (div_step == 6'h20) begin
            div_busy <= 1'b0;
            ratio    <= (bit_cnt == 48'h0000_0000_0000) ? 32'h0000_0000 : ratio_q; // R15
        end else begin
            div_step <= div_step + 6'h01;
            if ({div_rem[46:0], 1'b0} >= bit_cnt) begin
                div_rem <= {div_rem[46:0], 1'b0} - bit_cnt; // R15
                ratio_q <= {ratio_q[30:0], 1'b1};
            end else begin
                div_rem <= {div_rem[46:0], 1'b0};
                ratio_q <= {ratio_q[30:0], 1'b0};
            end
        end
    end

    // Status pins: three flops, change taken when second and third agree
    // Levels only; short pulses may be missed
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            link_s  <= 3'h0;
            pll_s   <= 3'h0;
            link_st <= 1'b0;
            pll_st  <= 1'b0;
        end else begin
            link_s <= {link_s[1:0], i_link_up};
            pll_s  <= {pll_s[1:0], i_pll_lock};
            if (link_s[1] == link_s[2])
                link_st <= link_s[2]; // R16
            if (pll_s[1] == pll_s[2])
                pll_st <= pll_s[2]; // R17
        end
    end

    // Clock meters: sampled user clocks counted over a fixed gate.
    // Sampling at 10 MHz only resolves clocks below 5 MHz; faster ones
    // alias, so fast clocks must be divided down before this input.
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            gate_cnt <= GATE_LAST[11:0];
            for (k = 0; k < 4; k = k + 1) begin
                clk_s[k]    <= 3'h0;
                edge_cnt[k] <= 16'h0000;
                clk_mhz[k]  <= 8'h00;
            end
        end else begin
            gate_cnt <= gate_end ? GATE_LAST[11:0] : (gate_cnt - 12'd1);
            for (k = 0; k < 4; k = k + 1) begin
                clk_s[k] <= {clk_s[k][1:0], clk_in[k]};
                if (gate_end) begin
                    // Edges per 100 us times 3/256 (about a divide by 85) gives MHz
                    clk_mhz[k]  <= edge_cnt[k][14:7] + edge_cnt[k][15:8]; // R19
                    edge_cnt[k] <= 16'h0000;
                end else if (clk_s[k][1] && !clk_s[k][2]) begin
                    edge_cnt[k] <= edge_cnt[k] + 16'h0001; // R19
                end
            end
        end
    end

    // Config port master: one access per bus request, enable pulsed one cycle, then wait for ready
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_dcp_addr  <= 8'h00;
            o_dcp_wdata <= 16'h0000;
            o_dcp_we    <= 1'b0;
            o_dcp_en    <= 1'b0;
            dcp_busy    <= 1'b0;
            dcp_rd_pend <= 1'b0;
            dcp_data    <= 16'h0000;
        end else begin
            o_dcp_en <= 1'b0;
            o_dcp_we <= 1'b0;
            if (wr && (i_avs_address == `SBT_OFF_DCP_ADDR))
                o_dcp_addr <= i_avs_writedata[7:0];
            if (dcp_acc && !dcp_busy && !dcp_rd_pend) begin
                o_dcp_en    <= 1'b1; // R20
                o_dcp_we    <= wr; // R20
                o_dcp_wdata <= i_avs_writedata[15:0];
                dcp_rd_pend <= 1'b1;
            end else if (dcp_rd_pend && i_dcp_ready) begin
                dcp_data    <= i_dcp_rdata; // R20
                dcp_busy    <= 1'b1;
                dcp_rd_pend <= 1'b0;
            end else if (dcp_busy && !o_avs_waitrequest) begin
                // Kept until the bus takes it
                dcp_busy <= 1'b0;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (i_avs_address)
            `SBT_OFF_CTRL:     next_rdata = {27'h0, ctrl[4:3], o_loopback};
            `SBT_OFF_PATTERN:  next_rdata = {25'h0, o_rx_pattern, 1'b0, o_tx_pattern};
            `SBT_OFF_STATUS:   next_rdata = {28'h0, o_chan_rst, o_pair_rst, pll_st, link_st};
            `SBT_OFF_BITCNT:   next_rdata = bit_cnt[47:16];
            `SBT_OFF_ERRCNT:   next_rdata = err_cnt;
            `SBT_OFF_RATIO:    next_rdata = ratio;
            `SBT_OFF_LINERATE: next_rdata = link_st ? {24'h0, clk_mhz[2]} : 32'h0; // R16
            `SBT_OFF_FREQ01:   next_rdata = {16'h0, clk_mhz[1], clk_mhz[0]};
            `SBT_OFF_FREQ23:   next_rdata = {16'h0, clk_mhz[3], clk_mhz[2]};
            `SBT_OFF_DCP_ADDR: next_rdata = {24'h0, o_dcp_addr};
            `SBT_OFF_DCP_DATA: next_rdata = {16'h0, dcp_data};
            `SBT_OFF_PORT_WR:  next_rdata = {16'h0, o_port_ctrl};
            `SBT_OFF_PORT_RD:  next_rdata = {16'h0, i_port_status}; // R21
            default:           next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered each cycle; it stands at the accepting edge
    // since the address is held from the edge before
    always @(posedge i_clk) begin
        if (!i_rst_b)
            o_avs_readdata <= 32'h0000_0000;
        else
            o_avs_readdata <= next_rdata; // R23
    end

    // Read acknowledge, one cycle after the
    // address or after the port answer is
    // latched; a plain read gets one wait
    always @(posedge i_clk) begin
        if (!i_rst_b)
            rd_ack <= 1'b0;
        else
            rd_ack <= rd && !rd_ack && (!dcp_acc || dcp_busy); // R23
    end

endmodule

// *** test/sbt_control_properties.sv ***
/*
 * Port assertions for the bit error tester control block.
 * Assumes a bind from the bench and a single clock domain.
 */
`timescale 1ns/1ps
`include "sbt_defines.vh"
module sbt_control_properties (
    input logic        i_clk,
    input logic        i_rst_b,
    input logic [7:0]  i_avs_address,
    input logic        i_avs_write,
    input logic [31:0] i_avs_writedata,
    input logic        o_avs_waitrequest,
    input logic [2:0]  o_loopback,
    input logic        o_lb_ne_pcs,
    input logic        o_lb_ne_pma,
    input logic        o_lb_fe_pma,
    input logic        o_lb_fe_pcs,
    input logic        o_pair_rst,
    input logic        o_chan_rst,
    input logic        o_tx_invert,
    input logic        o_rx_invert,
    input logic        o_err_inject,
    input logic        o_tx_cm_rst,
    input logic        o_rx_cm_rst,
    input logic [15:0] o_port_ctrl
);
    // Accepted writes by target; effects show from the next edge
    wire        wr  = i_avs_write && !o_avs_waitrequest;
    wire        cmd = wr && i_avs_address == `SBT_OFF_CMD;
    wire        ctl = wr && i_avs_address == `SBT_OFF_CTRL;
    wire [31:0] wd  = i_avs_writedata;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    property p_lb_none;
        o_loopback == `SBT_LB_NONE |-> !(o_lb_ne_pcs | o_lb_ne_pma | o_lb_fe_pma | o_lb_fe_pcs);
    endproperty
    a_lb_none: assert property (p_lb_none) else $error("loop path on in none mode");
    property p_pair;
        cmd && wd[0] |=> (o_pair_rst && o_chan_rst) [*8];
    endproperty
    a_pair: assert property (p_pair) else $error("pair reset too short");
    // Channel reset must leave the pair reset alone
    property p_chan;
        cmd && wd[1] && !wd[0] && !o_pair_rst |=> (o_chan_rst && !o_pair_rst) [*8];
    endproperty
    a_chan: assert property (p_chan) else $error("channel reset wrong");
    property p_txinv;
        ctl |=> o_tx_invert == $past(wd[3]);
    endproperty
    a_txinv: assert property (p_txinv) else $error("tx invert not applied");
    property p_rxinv;
        ctl |=> o_rx_invert == $past(wd[4]);
    endproperty
    a_rxinv: assert property (p_rxinv) else $error("rx invert not applied");
    property p_inject;
        cmd && wd[2] |=> o_err_inject ##1 !o_err_inject;
    endproperty
    a_inject: assert property (p_inject) else $error("inject not one pulse");
    property p_txcm;
        cmd && wd[4] && !wd[5] && !o_rx_cm_rst |=> (o_tx_cm_rst && !o_rx_cm_rst) [*8];
    endproperty
    a_txcm: assert property (p_txcm) else $error("clock manager resets mixed");
    property p_port;
        wr && i_avs_address == `SBT_OFF_PORT_WR |=> o_port_ctrl == $past(wd[15:0]);
    endproperty
    a_port: assert property (p_port) else $error("port value late");
endmodule

// *** test/sbt_link_model.sv ***
/*
 * Far-side transceiver model: checker word results, user clocks, config port.
 * Assumes the bench holds i_go high for one cycle per wanted word.
 */
`timescale 1ns/1ps
module sbt_link_model (
    input  logic        i_clk,
    input  logic        i_go,
    input  logic [7:0]  i_addr,
    input  logic [15:0] i_wdata,
    input  logic        i_we,
    input  logic        i_en,
    output logic        o_valid = 1'b0,
    output logic [5:0]  o_bits = 6'h17,
    output logic [5:0]  o_errs = 6'h3F,
    output logic [3:0]  o_uclk = 4'h0,
    output logic [15:0] o_rdata = 16'h0,
    output logic        o_ready = 1'b0
);
    logic [15:0] mem [256];
    int          words = 0;

    // Free-running user clocks: 4, 2, 2 and 1 MHz
    always #125 o_uclk[0] = ~o_uclk[0];
    always #250 o_uclk[1] = ~o_uclk[1];
    always #250 o_uclk[2] = ~o_uclk[2];
    always #500 o_uclk[3] = ~o_uclk[3];

    // 40-bit words; every hundredth has one error; idle lines show junk
    always @(posedge i_clk) begin
        o_valid <= i_go;
        o_bits <= i_go ? 6'h28 : 6'h17;
        o_errs <= i_go ? ((words % 100 == 99) ? 6'h01 : 6'h00) : 6'h3F;
        if (i_go)
            words <= words + 1;
    end

    // Config port stores at once; data toggles when not answering
    always @(posedge i_clk) begin
        o_ready <= i_en;
        o_rdata <= i_en ? (i_we ? i_wdata : mem[i_addr]) : ~o_rdata;
        if (i_en && i_we)
            mem[i_addr] <= i_wdata;
    end
endmodule

// *** test/tb.sv ***
/*
 * Self-checking bench for the control block over its Avalon-MM slave.
 * Assumes the link model and the property checker are compiled first.
 */
`timescale 1ns/1ps
`include "sbt_defines.vh"
bind sbt_control sbt_control_properties u_props (.*);
module tb;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic [7:0]  i_avs_address = 8'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic        i_link_up = 1'b0;
    logic        i_pll_lock = 1'b0;
    logic        go = 1'b0;
    logic [31:0] q;
    logic [2:0]  lb;
    logic [3:0]  oh;
    int          errors = 0;
    int          compares = 0;
    int          cnt [5] = '{default: 0};
    int          snap [5];
    int          cmd_bit [5] = '{0, 1, 4, 5, 2};
    logic [4:0]  hits [5] = '{5'h03, 5'h02, 5'h04, 5'h08, 5'h10};
    wire [31:0]  o_avs_readdata;
    wire [15:0]  o_dcp_wdata, o_port_ctrl, i_dcp_rdata;
    wire [7:0]   o_dcp_addr;
    wire [5:0]   i_rx_word_bits, i_rx_word_errs;
    wire [3:0]   uclk;
    wire [2:0]   o_loopback, o_tx_pattern, o_rx_pattern;
    wire         o_avs_waitrequest, o_lb_ne_pcs, o_lb_ne_pma, o_lb_fe_pma, o_lb_fe_pcs;
    wire         o_pair_rst, o_chan_rst, o_tx_invert, o_rx_invert, o_err_inject;
    wire         o_tx_cm_rst, o_rx_cm_rst, o_dcp_we, o_dcp_en, i_dcp_ready, i_rx_word_valid;
    wire         i_tx_user_clock = uclk[0];
    wire         i_tx_user_clock_fabric = uclk[1];
    wire         i_rx_user_clock = uclk[2];
    wire         i_rx_user_clock_fabric = uclk[3];
    wire [15:0]  i_port_status = 16'hA5C3;
    wire [4:0]   pulses = {o_err_inject, o_rx_cm_rst, o_tx_cm_rst, o_chan_rst, o_pair_rst};

    sbt_control dut (.*);
    sbt_link_model link (.i_clk(i_clk), .i_go(go), .i_addr(o_dcp_addr), .i_wdata(o_dcp_wdata),
        .i_we(o_dcp_we), .i_en(o_dcp_en), .o_valid(i_rx_word_valid), .o_bits(i_rx_word_bits),
        .o_errs(i_rx_word_errs), .o_uclk(uclk), .o_rdata(i_dcp_rdata), .o_ready(i_dcp_ready));

    always #50 i_clk = ~i_clk;

    // Cycles high of pair, channel, tx and rx manager resets and inject
    always @(posedge i_clk)
        for (int k = 0; k < 5; k++)
            cnt[k] <= cnt[k] + int'(pulses[k] === 1'b1);

    task test_done;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Meters and ratio are approximate, so one count either way is allowed
    task near(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if ((got + 1 >= exp && got <= exp + 1) !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: got %h near %h", $time, got, exp);
        end
    endtask

    // One bus cycle; read data is taken at the edge that sees waitrequest low
    task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_writedata <= d;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 200);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (o_avs_waitrequest !== 1'b0) begin
            errors++;
            $display("mismatch at %0t: bus timeout", $time);
            test_done();
        end else begin
            // One edge more so written outputs have settled
            @(posedge i_clk);
        end
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        bus(0, `SBT_OFF_CTRL, 0);
        check(q, `SBT_CTRL_RESET);
        // All loop codes plus an invalid one; inverts follow the low code bits
        for (int c = 0; c < 6; c++) begin
            lb = (c < 5) ? c[2:0] : `SBT_LB_NONE;
            oh = (c > 0 && c < 5) ? 4'h1 << (c - 1) : 4'h0;
            bus(1, `SBT_OFF_CTRL, c | (c << 3));
            check({o_loopback, o_lb_fe_pcs, o_lb_fe_pma, o_lb_ne_pma, o_lb_ne_pcs,
                   o_rx_invert, o_tx_invert}, {lb, oh, c[1:0]});
        end
        // Tx and rx patterns differ each step; the last code is reserved
        for (int p = 0; p < 7; p++) begin
            bus(1, `SBT_OFF_PATTERN, (p < 6) ? ((5 - p) << 4 | p) : 32'h77);
            check({o_rx_pattern, o_tx_pattern}, (p < 6) ? {3'(5 - p), 3'(p)} : 6'h05);
        end
        // Each command but test reset, alone: which outputs move and for how long
        for (int i = 0; i < 5; i++) begin
            snap = cnt;
            bus(1, `SBT_OFF_CMD, 32'h1 << cmd_bit[i]);
            repeat (25) @(posedge i_clk);
            for (int k = 0; k < 5; k++)
                check(cnt[k] - snap[k],
                      hits[i][k] ? ((k == 4) ? 1 : `SBT_RST_CYCLES) : 0);
        end
        bus(1, `SBT_OFF_DCP_ADDR, 32'h2A);
        bus(1, `SBT_OFF_DCP_DATA, 32'hBEEF);
        check({o_dcp_addr, o_dcp_wdata}, 24'h2ABEEF);
        bus(0, `SBT_OFF_DCP_DATA, 0);
        check(q[15:0], 16'hBEEF);
        bus(1, `SBT_OFF_PORT_WR, 32'h1234);
        check(o_port_ctrl, 16'h1234);
        bus(1, `SBT_OFF_PORT_RD, 32'h0);
        bus(0, `SBT_OFF_PORT_RD, 0);
        check(q, 32'hA5C3);
        bus(0, 8'h3C, 0);
        check(q, 0);
        // Unlocked first, then locked with the meters given two gates to settle
        bus(0, `SBT_OFF_STATUS, 0);
        check(q[1:0], 2'h0);
        bus(0, `SBT_OFF_LINERATE, 0);
        check(q, 0);
        i_link_up <= 1'b1;
        i_pll_lock <= 1'b1;
        repeat (2100) @(posedge i_clk);
        bus(0, `SBT_OFF_STATUS, 0);
        check(q[1:0], 2'h3);
        bus(0, `SBT_OFF_LINERATE, 0);
        near(q, 2);
        bus(0, `SBT_OFF_FREQ01, 0);
        near(q[7:0], 4);
        near(q[15:8], 2);
        bus(0, `SBT_OFF_FREQ23, 0);
        near(q[7:0], 2);
        near(q[15:8], 1);
        // 2000 words of 40 bits with 20 errors, from a clean start
        bus(1, `SBT_OFF_CMD, 32'h8);
        go <= 1'b1;
        repeat (2000) @(posedge i_clk);
        go <= 1'b0;
        repeat (80) @(posedge i_clk);
        bus(0, `SBT_OFF_BITCNT, 0);
        check(q, 32'h1);
        bus(0, `SBT_OFF_ERRCNT, 0);
        check(q, 32'h14);
        bus(0, `SBT_OFF_RATIO, 0);
        near(q, 32'h10624D);
        bus(1, `SBT_OFF_CMD, 32'h8);
        repeat (80) @(posedge i_clk);
        bus(0, `SBT_OFF_BITCNT, 0);
        check(q, 0);
        bus(0, `SBT_OFF_ERRCNT, 0);
        check(q, 0);
        bus(0, `SBT_OFF_RATIO, 0);
        check(q, 0);
        test_done();
    end
endmodule
